/* File: hw/oag_operand_address_generator.v */
// Operand address generator: maps operand forms to register/program addresses
`timescale 1ns/1ps
`default_nettype none
`include "oag_regs.vh"

// Summary of operation
// - Immediate operand is fetched from program memory after the opcode.
// - Working register n maps to pointer low, pointer high, then n.
// - Working pair uses even index only, same pointer concatenation.
// - 8-bit register 00h-DFh or F0h-FFh maps to pointer low above operand.
// - Escaped range E0h-EFh maps to working register via pointer nibbles.
// - 8-bit register pair maps exactly like single 8-bit register.
// - Indirect working register: pointer low above its 8-bit content.
// - Indirect working pair: 12-bit register or 16-bit program address.
// - Indirect 8-bit register: pointer low above that register's content.
// - Indirect register pair yields a 16-bit program memory address.
// - Indexed: base plus signed offset register, pointer low above.
// - Direct jump loads program counter with 16-bit address.
// - Relative jump adds signed 8-bit offset to next instruction address.
module oag_operand_address_generator (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Register pointer
  input  wire [7:0]  register_pointer,
  // Request from decode
  input  wire        reqValid,
  input  wire [3:0]  reqMode,
  input  wire [7:0]  reqOperand,
  input  wire [7:0]  reqOperandHi,
  input  wire [15:0] nextPc,
  input  wire        reqProgSpace,
  // Register-file read port for effective address fetch
  output reg         rfRead,
  output reg  [11:0] rfAddr,
  input  wire [7:0]  rfData,
  // Answer
  output reg         ansValid,
  output reg  [1:0]  ansKind,
  output reg  [11:0] ansRegAddr,
  output reg  [15:0] ansProgAddr,
  output reg         ansBadPair,
  output reg         busy
);

  // One-hot sequencer states
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_RD0  = 4'b0010;
  localparam [3:0] ST_RD1  = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;

  // Working register address from a 4-bit index
  function [11:0] wregAddr;
    input [7:0] rp;
    input [3:0] n;
    begin
      wregAddr = {rp[`OAG_RP_LO_MSB:0], rp[7:`OAG_RP_HI_LSB], n};
    end
  endfunction

  // 8-bit register address with escaped range substitution
  function [11:0] reg8Addr;
    input [7:0] rp;
    input [7:0] aa;
    begin
      if (aa[7:4] == `OAG_ESC_NIBBLE) begin
        reg8Addr = wregAddr(rp, aa[3:0]);
      end else begin
        reg8Addr = {rp[`OAG_RP_LO_MSB:0], aa};
      end
    end
  endfunction

  reg [3:0]  state_q;
  reg [3:0]  mode_q;
  reg [7:0]  operand_q;
  reg        progSpace_q;
  reg [7:0]  firstByte_q;
  reg [11:0] pairAddr_q;

  // Sequencer: single-cycle forms answer directly, indirect forms read first
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      mode_q      <= 4'h0;
      operand_q   <= 8'h00;
      progSpace_q <= 1'b0;
      firstByte_q <= 8'h00;
      pairAddr_q  <= 12'h000;
      rfRead      <= 1'b0;
      rfAddr      <= 12'h000;
      ansValid    <= 1'b0;
      ansKind     <= `OAG_KIND_NONE;
      ansRegAddr  <= 12'h000;
      ansProgAddr <= 16'h0000;
      ansBadPair  <= 1'b0;
      busy        <= 1'b0;
    end else begin
      ansValid <= 1'b0;
      rfRead   <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (reqValid) begin
            mode_q      <= reqMode;
            operand_q   <= reqOperand;
            progSpace_q <= reqProgSpace;
            ansBadPair  <= 1'b0;
            case (reqMode)
              `OAG_MODE_IMM: begin
                ansValid    <= 1'b1;
                ansKind     <= `OAG_KIND_PROG;
                ansProgAddr <= nextPc;
              end
              `OAG_MODE_WREG: begin
                ansValid   <= 1'b1;
                ansKind    <= `OAG_KIND_REG;
                ansRegAddr <= wregAddr(register_pointer, reqOperand[3:0]);
              end
              `OAG_MODE_WPAIR: begin
                ansValid   <= 1'b1;
                ansKind    <= `OAG_KIND_REG;
                ansBadPair <= reqOperand[0];
                ansRegAddr <= wregAddr(register_pointer,
                                       {reqOperand[3:1], 1'b0});
              end
              `OAG_MODE_REG8, `OAG_MODE_PAIR8: begin
                ansValid   <= 1'b1;
                ansKind    <= `OAG_KIND_REG;
                ansRegAddr <= reg8Addr(register_pointer, reqOperand);
                ansBadPair <= (reqMode == `OAG_MODE_PAIR8) & reqOperand[0];
              end
              `OAG_MODE_JPABS: begin
                ansValid    <= 1'b1;
                ansKind     <= `OAG_KIND_PC;
                ansProgAddr <= {reqOperandHi, reqOperand};
              end
              `OAG_MODE_JPREL: begin
                ansValid    <= 1'b1;
                ansKind     <= `OAG_KIND_PC;
                ansProgAddr <= nextPc +
                               {{8{reqOperand[7]}}, reqOperand};
              end
              `OAG_MODE_IWREG, `OAG_MODE_INDEX: begin
                // Index register holds the signed offset
                state_q <= ST_RD0;
                busy    <= 1'b1;
                rfRead  <= 1'b1;
                rfAddr  <= wregAddr(register_pointer, reqOperand[3:0]);
              end
              `OAG_MODE_IWPAIR: begin
                state_q    <= ST_RD0;
                busy       <= 1'b1;
                rfRead     <= 1'b1;
                pairAddr_q <= wregAddr(register_pointer,
                                       {reqOperand[3:1], 1'b0});
                rfAddr     <= wregAddr(register_pointer,
                                       {reqOperand[3:1], 1'b0});
              end
              `OAG_MODE_IREG8, `OAG_MODE_IPAIR8: begin
                state_q    <= ST_RD0;
                busy       <= 1'b1;
                rfRead     <= 1'b1;
                pairAddr_q <= reg8Addr(register_pointer, reqOperand);
                rfAddr     <= reg8Addr(register_pointer, reqOperand);
              end
              default: begin
                // Unknown mode answers with no destination
                ansValid <= 1'b1;
                ansKind  <= `OAG_KIND_NONE;
              end
            endcase
            // Index base travels in the high operand byte
            if (reqMode == `OAG_MODE_INDEX) begin
              operand_q <= reqOperandHi;
            end
          end
        end
        ST_RD0: begin
          // Read data is valid the cycle after rfRead
          state_q <= ST_RD1;
        end
        ST_RD1: begin
          firstByte_q <= rfData;
          if (mode_q == `OAG_MODE_IWREG || mode_q == `OAG_MODE_IREG8) begin
            ansKind    <= `OAG_KIND_REG;
            ansRegAddr <= {register_pointer[`OAG_RP_LO_MSB:0],
                           rfData};
            state_q    <= ST_DONE;
            ansValid   <= 1'b1;
            busy       <= 1'b0;
          end else if (mode_q == `OAG_MODE_INDEX) begin
            // 8-bit add wraps, pointer bits untouched
            ansKind    <= `OAG_KIND_REG;
            ansRegAddr <= {register_pointer[`OAG_RP_LO_MSB:0],
                           operand_q + rfData};
            state_q    <= ST_DONE;
            ansValid   <= 1'b1;
            busy       <= 1'b0;
          end else if (rfAddr == pairAddr_q) begin
            // Fetch low byte of the pair next
            rfRead  <= 1'b1;
            rfAddr  <= pairAddr_q + 12'h001;
            state_q <= ST_RD0;
          end else begin
            // Pair complete: high byte first, low byte second
            ansValid <= 1'b1;
            busy     <= 1'b0;
            state_q  <= ST_DONE;
            if (mode_q == `OAG_MODE_IWPAIR && !progSpace_q) begin
              ansKind    <= `OAG_KIND_REG;
              ansRegAddr <= {firstByte_q[3:0], rfData};
            end else begin
              ansKind     <= `OAG_KIND_PROG;
              ansProgAddr <= {firstByte_q, rfData};
            end
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: hw/oag_regs.vh */
// Operand address generator constants: mode codes, ranges and widths
`ifndef OAG_REGS_VH
`define OAG_REGS_VH

// Operand mode codes presented on reqMode
`define OAG_MODE_IMM    4'h0
`define OAG_MODE_WREG   4'h1
`define OAG_MODE_WPAIR  4'h2
`define OAG_MODE_REG8   4'h3
`define OAG_MODE_PAIR8  4'h4
`define OAG_MODE_IWREG  4'h5
`define OAG_MODE_IWPAIR 4'h6
`define OAG_MODE_IREG8  4'h7
`define OAG_MODE_IPAIR8 4'h8
`define OAG_MODE_INDEX  4'h9
`define OAG_MODE_JPABS  4'ha
`define OAG_MODE_JPREL  4'hb

// Escaped 8-bit register range high nibble (E0h-EFh)
`define OAG_ESC_NIBBLE  4'he

// Pointer field positions
`define OAG_RP_LO_MSB   3
`define OAG_RP_HI_LSB   4

// Answer destinations on ansKind
`define OAG_KIND_NONE   2'h0
`define OAG_KIND_REG    2'h1
`define OAG_KIND_PROG   2'h2
`define OAG_KIND_PC     2'h3

`endif

/* File: test/oag_operand_address_generator_props.sv */
// Checker: port assertions for the operand address generator
`timescale 1ns/1ps
`default_nettype none
`include "oag_regs.vh"
module oag_operand_address_generator_props (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Request side
  input wire [7:0]  register_pointer,
  input wire        reqValid,
  input wire [3:0]  reqMode,
  input wire [7:0]  reqOperand,
  input wire [7:0]  reqOperandHi,
  input wire [15:0] nextPc,
  input wire [7:0]  rfData,
  // Answer side
  input wire        rfRead,
  input wire [11:0] rfAddr,
  input wire        ansValid,
  input wire [1:0]  ansKind,
  input wire [11:0] ansRegAddr,
  input wire [15:0] ansProgAddr,
  input wire        busy
);
  reg  [1:0]  bh_q;
  wire [7:0]  rp = register_pointer;
  wire [11:0] wAddr = {rp[3:0], rp[7:4], reqOperand[3:0]};
  wire        esc = reqOperand[7:4] == `OAG_ESC_NIBBLE;
  wire [11:0] rAddr = esc ? wAddr : {rp[3:0], reqOperand};
  wire [15:0] absPc = {reqOperandHi, reqOperand};
  wire [15:0] relPc = nextPc + {{8{reqOperand[7]}}, reqOperand};
  wire        take = reqValid && !busy && bh_q == 2'h0;
  // Busy history: take skips the two cycles after an indirect sequence; only the first refuses requests
  always @(posedge clk or posedge rst) begin
    if (rst)
      bh_q <= 2'h0;
    else
      bh_q <= {bh_q[0], busy};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_wreg_map: assert property (
    take && reqMode == `OAG_MODE_WREG |=>
    ansValid && ansRegAddr == $past(wAddr)) else $error("wreg addr wrong");
  chk_reg8_map: assert property (
    take && reqMode == `OAG_MODE_REG8 |=>
    ansValid && ansRegAddr == $past(rAddr)) else $error("reg8 addr wrong");
  chk_pair8_map: assert property (
    take && reqMode == `OAG_MODE_PAIR8 |=>
    ansValid && ansRegAddr == $past(rAddr)) else $error("pair8 addr wrong");
  chk_imm_fetch: assert property (
    take && reqMode == `OAG_MODE_IMM |=>
    ansKind == `OAG_KIND_PROG && ansProgAddr == $past(nextPc))
    else $error("immediate fetch addr wrong");
  chk_jump_abs: assert property (
    take && reqMode == `OAG_MODE_JPABS |=>
    ansKind == `OAG_KIND_PC && ansProgAddr == $past(absPc))
    else $error("absolute jump wrong");
  chk_jump_rel: assert property (
    take && reqMode == `OAG_MODE_JPREL |=>
    ansKind == `OAG_KIND_PC && ansProgAddr == $past(relPc))
    else $error("relative jump wrong");
  chk_iwreg_seq: assert property (
    take && reqMode == `OAG_MODE_IWREG |=>
    rfRead && busy && rfAddr == $past(wAddr) ##2
    ansValid && ansRegAddr == {rp[3:0], $past(rfData)})
    else $error("indirect wreg sequence wrong");
  chk_index_wrap: assert property (
    take && reqMode == `OAG_MODE_INDEX |=>
    rfRead ##2 ansValid && ansRegAddr[11:8] == rp[3:0] &&
    ansRegAddr[7:0] == $past(reqOperandHi, 3) + $past(rfData))
    else $error("indexed addr wrong");
endmodule
bind oag_operand_address_generator oag_operand_address_generator_props chk (.*);
`default_nettype wire

/* File: test/tb_operand_address_generator.sv */
// Testbench: directed scenarios for the operand address generator
`timescale 1ns/1ps
`default_nettype none
`include "oag_regs.vh"
module tb_operand_address_generator;
  logic        clk, rst, reqValid, reqProgSpace;
  logic        rfRead, ansValid, ansBadPair, busy;
  logic [3:0]  reqMode;
  logic [7:0]  register_pointer, reqOperand, reqOperandHi, rfData;
  logic [11:0] rfAddr, ansRegAddr;
  logic [15:0] nextPc, ansProgAddr;
  logic [1:0]  ansKind;
  integer      failures, n_checks;
  oag_operand_address_generator dut (
    .clk              (clk),
    .rst              (rst),
    .register_pointer (register_pointer),
    .reqValid         (reqValid),
    .reqMode          (reqMode),
    .reqOperand       (reqOperand),
    .reqOperandHi     (reqOperandHi),
    .nextPc           (nextPc),
    .reqProgSpace     (reqProgSpace),
    .rfRead           (rfRead),
    .rfAddr           (rfAddr),
    .rfData           (rfData),
    .ansValid         (ansValid),
    .ansKind          (ansKind),
    .ansRegAddr       (ansRegAddr),
    .ansProgAddr      (ansProgAddr),
    .ansBadPair       (ansBadPair),
    .busy             (busy)
  );
  // Clock at 125 MHz
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // Register file stand-in: contents are the address xor a fixed pattern
  always @(negedge clk) rfData <= rfAddr[7:0] ^ 8'h3c;
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One request, then wait a bounded time for its answer and judge it
  task automatic op(input logic [3:0] m, input logic [7:0] o, h,
                    input logic [15:0] pc, input logic [1:0] k,
                    input logic [15:0] e);
    integer i;
    repeat (2) @(negedge clk); // Gap keeps clear of the refused cycles
    reqValid = 1'h1;
    reqMode = m;
    reqOperand = o;
    reqOperandHi = h;
    nextPc = pc;
    @(negedge clk);
    reqValid = 1'h0;
    for (i = 0; i < 8 && ansValid !== 1'h1; i++) @(negedge clk);
    if (ansValid !== 1'h1) begin
      failures++;
      tally_and_finish();
    end
    cmp({14'h0000, ansKind}, {14'h0000, k});
    cmp(k == 2'h1 ? {4'h0, ansRegAddr} : ansProgAddr, e);
  endtask
  task automatic test_direct;
    register_pointer = 8'h5a;
    op(`OAG_MODE_WREG, 8'h07, 8'h00, 16'h0000, 2'h1, 16'h0a57);
    op(`OAG_MODE_WPAIR, 8'h05, 8'h00, 16'h0000, 2'h1, 16'h0a54);
    cmp({15'h0000, ansBadPair}, 16'h0001);
    op(`OAG_MODE_REG8, 8'h3c, 8'h00, 16'h0000, 2'h1, 16'h0a3c);
    op(`OAG_MODE_REG8, 8'he9, 8'h00, 16'h0000, 2'h1, 16'h0a59);
    op(`OAG_MODE_PAIR8, 8'hf2, 8'h00, 16'h0000, 2'h1, 16'h0af2);
    cmp({15'h0000, ansBadPair}, 16'h0000);
    op(`OAG_MODE_PAIR8, 8'he4, 8'h00, 16'h0000, 2'h1, 16'h0a54);
    op(`OAG_MODE_IMM, 8'h00, 8'h00, 16'h1234, 2'h2, 16'h1234);
    op(`OAG_MODE_JPABS, 8'h34, 8'h12, 16'h0000, 2'h3, 16'h1234);
    op(`OAG_MODE_JPREL, 8'h80, 8'h00, 16'h1000, 2'h3, 16'h0f80);
    op(`OAG_MODE_JPREL, 8'h7f, 8'h00, 16'hfff0, 2'h3, 16'h006f);
    $display("direct modes done");
  endtask
  task automatic test_indirect;
    op(`OAG_MODE_IWREG, 8'h03, 8'h00, 16'h0000, 2'h1, 16'h0a6f);
    op(`OAG_MODE_IREG8, 8'h10, 8'h00, 16'h0000, 2'h1, 16'h0a2c);
    op(`OAG_MODE_INDEX, 8'h04, 8'hf0, 16'h0, 2'h1, 16'h0a58);
    reqProgSpace = 1'h1;
    op(`OAG_MODE_IWPAIR, 8'h02, 8'h00, 16'h0000, 2'h2, 16'h6e6f);
    reqProgSpace = 1'h0;
    op(`OAG_MODE_IWPAIR, 8'h02, 8'h00, 16'h0000, 2'h1, 16'h0e6f);
    op(`OAG_MODE_IPAIR8, 8'h10, 8'h00, 16'h0000, 2'h2, 16'h2c2d);
    $display("indirect modes done");
  endtask
  // Reset for 16 cycles, then the scenarios
  initial begin
    failures = 0;
    n_checks = 0;
    rst = 1'h1;
    {reqValid, reqProgSpace, reqMode, reqOperand} = 14'h0000;
    {register_pointer, reqOperandHi, nextPc} = 32'h0;
    repeat (16) @(negedge clk);
    rst = 1'h0;
    test_direct();
    test_indirect();
    tally_and_finish();
  end
endmodule
`default_nettype wire
